// ### verilog/charger_status_telemetry_regs.sv
// Status, alert and telemetry register bank behind the two-wire port
`timescale 1ns/100ps
module charger_status_telemetry_regs
	import charger_regs_pkg::*;
	#(
	parameter logic [6:0] DEVICE_ADDR = 7'h2a, // Arbitrary value
	parameter int NUM_THRESH = REGION_THRESH_COUNT
	)
	(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Two-wire port pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_drive_n,
	// Open-drain alert pin
	input wire logic smbalert_in,
	output logic smbalert_out,
	output logic smbalert_drive_n,
	// Asynchronous pins and comparators
	input wire sys_in_type sys_pins,
	input wire logic mppt_pin,
	input wire logic equalize_pin,
	input wire logic [3:0] chemistry_select_pins,
	input wire logic [5:0] cell_select_pins,
	// Charger core, same clock
	input wire loop_type loop_active,
	input wire logic [3:0] alert_enable,
	input wire logic equalize_done,
	input wire logic [NUM_THRESH-1:0][15:0] region_thresh,
	// Measurement results, same clock
	input wire meas_type meas,
	input wire logic meas_strobe,
	input wire logic [15:0] bsr_value,
	input wire logic [15:0] resistance_calc_current,
	input wire logic bsr_strobe
	);

	localparam int SYNC_W = 23;
	// Serial pins rest high, so the flops reset to the idle bus level
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {{(SYNC_W-2){1'b0}}, 2'h3};

	logic [SYNC_W-1:0] pin_meta;
	logic [SYNC_W-1:0] pin_sync;
	logic scl_q;
	logic sda_q;
	logic eq_q;
	wire sys_in_type sys_s;
	wire logic mppt_s;
	wire logic eq_s;
	wire logic [3:0] chem_s;
	wire logic [5:0] cells_s;
	wire logic scl_s;
	wire logic sda_s;

	// Every pin passes two flops; idle reset avoids a false SCL edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta <= SYNC_IDLE;
			pin_sync <= SYNC_IDLE;
		end else begin
			pin_meta <= {sys_pins, mppt_pin, equalize_pin,
				chemistry_select_pins, cell_select_pins, scl, sda_in};
			pin_sync <= pin_meta;
		end
	end

	// Named slices of the synchronised pins
	assign {sys_s, mppt_s, eq_s, chem_s, cells_s, scl_s, sda_s} = pin_sync;

	// Delayed copies for edge detection
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			eq_q <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			eq_q <= eq_s;
		end
	end

	wire logic scl_rise = scl_s & ~scl_q;
	wire logic scl_fall = ~scl_s & scl_q;
	wire logic start_cond = scl_s & scl_q & sda_q & ~sda_s;
	wire logic stop_cond = scl_s & scl_q & ~sda_q & sda_s;
	wire logic eq_rise = eq_s & ~eq_q;

	// Held telemetry; only the producing strobes load these
	meas_type meas_reg;
	logic [15:0] bsr_reg;
	logic [15:0] bsr_current_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			meas_reg <= '0;
			bsr_reg <= 16'h0000;
			bsr_current_reg <= 16'h0000;
		end else begin
			if (meas_strobe)
				meas_reg <= meas;
			if (bsr_strobe) begin
				bsr_reg <= bsr_value;
				bsr_current_reg <= resistance_calc_current;
			end
		end
	end

	// Chemistry pin decode, CHEM1 in the upper pair
	logic [3:0] chem_code;
	always_comb begin
		case (chem_s)
			{LVL_L, LVL_L}: chem_code = 4'h0;
			{LVL_H, LVL_H}: chem_code = 4'h1;
			{LVL_L, LVL_Z}: chem_code = 4'h2;
			{LVL_Z, LVL_L}: chem_code = 4'h3;
			{LVL_L, LVL_H}: chem_code = 4'h4;
			{LVL_H, LVL_Z}: chem_code = 4'h5;
			{LVL_Z, LVL_H}: chem_code = 4'h6;
			{LVL_Z, LVL_Z}: chem_code = 4'h7;
			{LVL_H, LVL_L}: chem_code = 4'h8;
			default: chem_code = CHEM_INVALID;
		endcase
	end

	// Cell-count decode; any unlisted combination is an error
	logic [3:0] cell_code;
	always_comb begin
		case (cells_s)
			{LVL_L, LVL_L, LVL_H}: cell_code = 4'h1;
			{LVL_L, LVL_H, LVL_L}: cell_code = 4'h2;
			{LVL_L, LVL_H, LVL_H}: cell_code = 4'h3;
			{LVL_L, LVL_L, LVL_Z}: cell_code = 4'h4;
			{LVL_L, LVL_Z, LVL_L}: cell_code = 4'h5;
			{LVL_L, LVL_H, LVL_Z}: cell_code = 4'h6;
			{LVL_L, LVL_Z, LVL_H}: cell_code = 4'h7;
			{LVL_L, LVL_Z, LVL_Z}: cell_code = 4'h8;
			{LVL_H, LVL_L, LVL_L}: cell_code = 4'h9;
			{LVL_H, LVL_H, LVL_H}: cell_code = 4'hc;
			default: cell_code = CELLS_INVALID;
		endcase
	end

	wire logic cell_error = (cell_code == CELLS_INVALID);

	// Thermistor region: one step per threshold the ratio falls below
	logic [NUM_THRESH-1:0] below;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_THRESH; gi++) begin : g_thresh
			assign below[gi] = $signed(meas_reg.ntc_ratio) <
				$signed(region_thresh[gi]);
		end
	endgenerate

	logic [2:0] region_count;
	always_comb begin
		region_count = 3'h1;
		for (int i = 0; i < NUM_THRESH; i++)
			region_count = region_count + 3'(below[i]);
	end

	// Region only meaningful for lithium algorithms
	wire logic lithium = (chem_code <= CHEM_LAST_LITHIUM);
	wire logic [15:0] region_word =
		lithium ? {13'h0000, region_count} : 16'h0000;

	// Equalize request latches on the pin edge
	logic eq_req;
	wire logic next_eq_req = eq_rise | (eq_req & ~equalize_done);

	always_ff @(posedge clk) begin
		if (reset)
			eq_req <= 1'b0;
		else
			eq_req <= next_eq_req;
	end

	// Real-time status word, reserved bits read zero
	logic [15:0] status_word;
	always_comb begin
		status_word = 16'h0000;
		status_word[ST_CHARGER_ENABLED] = sys_s.charger_enabled;
		status_word[ST_MPPT] = mppt_s;
		status_word[ST_EQUALIZE] = eq_req;
		status_word[ST_DRIVE_GOOD] = sys_s.drive_supply_good;
		status_word[ST_CELL_ERROR] = cell_error;
		status_word[ST_PERMITTED] = sys_s.charge_permitted;
		status_word[ST_NO_FREQ_RES] = sys_s.missing_freq_resistor;
		status_word[ST_THERMAL] = sys_s.thermal_shutdown;
		status_word[ST_OVERVOLT] = sys_s.input_overvoltage;
		status_word[ST_IN_ABOVE_BAT] = sys_s.input_above_battery;
		status_word[ST_SW_LOCKOUT] =
			sys_s.int_supply_above_switch_lockout;
		status_word[ST_MEAS_LOCKOUT] =
			sys_s.int_supply_above_meas_lockout;
	end

	// Serial port registers
	port_state_type state;
	logic [3:0] bit_count;
	logic [7:0] shift_in;
	logic [7:0] tx_byte;
	logic [15:0] word_hold;
	logic [7:0] sub_addr;
	logic [7:0] low_byte;
	logic read_mode;
	logic ara_mode;
	logic high_next;
	logic master_ack;
	logic wr_pulse;
	logic [15:0] wr_data;
	logic ara_done;
	logic [ALERT_W-1:0] alert_flags;

	// Read mux; unmapped sub-addresses read zero
	logic [15:0] read_word;
	always_comb begin
		case (sub_addr)
			ADDR_ALERTS: read_word = {12'h000, alert_flags};
			ADDR_STATUS: read_word = status_word;
			ADDR_VBAT: read_word = meas_reg.vbat;
			ADDR_VIN: read_word = meas_reg.vin;
			ADDR_VSYS: read_word = meas_reg.vsys;
			ADDR_IBAT: read_word = meas_reg.ibat;
			ADDR_IIN: read_word = meas_reg.iin;
			ADDR_DIE_TEMP: read_word = meas_reg.die_temp;
			ADDR_NTC: read_word = meas_reg.ntc_ratio;
			ADDR_BSR: read_word = bsr_reg;
			ADDR_REGION: read_word = region_word;
			ADDR_CHEM_CELLS: read_word = {4'h0, chem_code, 4'h0, cell_code};
			ADDR_BSR_CURRENT: read_word = bsr_current_reg;
			default: read_word = 16'h0000;
		endcase
	end

	// Alert response returns our own address byte
	wire logic [15:0] load_word =
		ara_mode ? {8'h00, DEVICE_ADDR, 1'b0} : read_word;
	wire logic byte_done = (bit_count == BITS_PER_BYTE);
	wire logic addr_match = (shift_in[7:1] == DEVICE_ADDR);
	logic alert_pending;
	wire logic ara_match = (shift_in[7:1] == ALERT_RESPONSE_ADDR) &
		shift_in[0] & alert_pending;

	// Byte engine: sample on SCL rise, change SDA on SCL fall
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= S_IDLE;
			bit_count <= 4'h0;
			shift_in <= 8'h00;
			tx_byte <= 8'h00;
			word_hold <= 16'h0000;
			sub_addr <= 8'h00;
			low_byte <= 8'h00;
			read_mode <= 1'b0;
			ara_mode <= 1'b0;
			high_next <= 1'b0;
			master_ack <= 1'b0;
			wr_pulse <= 1'b0;
			wr_data <= 16'h0000;
			ara_done <= 1'b0;
			sda_drive_n <= 1'b1;
			sda_out <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			ara_done <= 1'b0;
			if (start_cond) begin
				state <= S_ADDR;
				bit_count <= 4'h0;
				sda_drive_n <= 1'b1;
			end else if (stop_cond) begin
				state <= S_IDLE;
				sda_drive_n <= 1'b1;
			end else if (scl_rise) begin
				shift_in <= {shift_in[6:0], sda_s};
				bit_count <= 4'(bit_count + 4'h1);
				if (state == S_RD_ACK) begin
					master_ack <= ~sda_s;
					ara_done <= ara_mode;
				end
			end else if (scl_fall) begin
				case (state)
					S_ADDR: begin
						if (byte_done && (addr_match || ara_match)) begin
							read_mode <= shift_in[0];
							ara_mode <= ~addr_match;
							sda_drive_n <= 1'b0;
							state <= S_ADDR_ACK;
						end else if (byte_done) begin
							state <= S_IDLE;
						end
					end
					S_ADDR_ACK: begin
						bit_count <= 4'h0;
						if (read_mode) begin
							word_hold <= load_word;
							tx_byte <= load_word[7:0];
							sda_drive_n <= load_word[7];
							high_next <= ~ara_mode;
							state <= S_RD;
						end else begin
							sda_drive_n <= 1'b1;
							state <= S_SUB;
						end
					end
					S_SUB: begin
						if (byte_done) begin
							sub_addr <= shift_in;
							sda_drive_n <= 1'b0;
							state <= S_SUB_ACK;
						end
					end
					S_SUB_ACK: begin
						sda_drive_n <= 1'b1;
						bit_count <= 4'h0;
						state <= S_WLO;
					end
					S_WLO: begin
						if (byte_done) begin
							low_byte <= shift_in;
							sda_drive_n <= 1'b0;
							state <= S_WLO_ACK;
						end
					end
					S_WLO_ACK: begin
						sda_drive_n <= 1'b1;
						bit_count <= 4'h0;
						state <= S_WHI;
					end
					S_WHI: begin
						if (byte_done) begin
							wr_data <= {shift_in, low_byte};
							wr_pulse <= 1'b1;
							sda_drive_n <= 1'b0;
							state <= S_WHI_ACK;
						end
					end
					S_WHI_ACK: begin
						sda_drive_n <= 1'b1;
						state <= S_IDLE;
					end
					S_RD: begin
						if (byte_done) begin
							sda_drive_n <= 1'b1;
							state <= S_RD_ACK;
						end else begin
							tx_byte <= {tx_byte[6:0], 1'b0};
							sda_drive_n <= tx_byte[6];
						end
					end
					S_RD_ACK: begin
						bit_count <= 4'h0;
						if (master_ack && high_next) begin
							tx_byte <= word_hold[15:8];
							sda_drive_n <= word_hold[15];
							high_next <= 1'b0;
							state <= S_RD;
						end else begin
							state <= S_IDLE;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Alert flags: only the alert word honours writes
	wire logic [ALERT_W-1:0] loop_bits = loop_active;
	wire logic [ALERT_W-1:0] alert_set = alert_enable & loop_bits;
	wire logic alert_write = wr_pulse && (sub_addr == ADDR_ALERTS);
	wire logic [ALERT_W-1:0] alert_clear =
		alert_write ? ~wr_data[ALERT_W-1:0] : '0;
	wire logic [ALERT_W-1:0] kept = alert_flags & ~alert_clear;
	// Set wins over clear, so a live condition comes straight back
	wire logic [ALERT_W-1:0] next_alert_flags =
		(kept | alert_set) & alert_enable;
	// Compared with the post-clear value so a re-raise alerts again
	wire logic new_alert = |(alert_set & ~kept);
	wire logic next_alert_pending = new_alert | (alert_pending & ~ara_done);

	always_ff @(posedge clk) begin
		if (reset) begin
			alert_flags <= '0;
			alert_pending <= 1'b0;
			smbalert_drive_n <= 1'b1;
			smbalert_out <= 1'b0;
		end else begin
			alert_flags <= next_alert_flags;
			alert_pending <= next_alert_pending;
			smbalert_drive_n <= ~next_alert_pending;
		end
	end

	// Checks on the alert, status and hold behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_ara_finish;
		ara_done ##0 !new_alert;
	endsequence

	property p_uvcl_alert;
		alert_enable[AL_UVCL] && loop_active.uvcl_active |=>
			alert_flags[AL_UVCL];
	endproperty
	a_uvcl_alert: assert property (p_uvcl_alert)
		else $error("uvcl alert not set");

	property p_iin_alert;
		alert_enable[AL_IIN_LIMIT] && loop_active.iin_limit_active |=>
			alert_flags[AL_IIN_LIMIT];
	endproperty
	a_iin_alert: assert property (p_iin_alert)
		else $error("input limit alert not set");

	property p_cc_alert;
		alert_enable[AL_CC] && $rose(loop_active.constant_current) |=>
			alert_flags[AL_CC] && !smbalert_drive_n;
	endproperty
	a_cc_alert: assert property (p_cc_alert)
		else $error("constant current alert missing");

	property p_cv_alert;
		!alert_enable[AL_CV] |=> !alert_flags[AL_CV];
	endproperty
	a_cv_alert: assert property (p_cv_alert)
		else $error("disabled voltage alert still set");

	property p_eq_hold;
		$rose(eq_s) ##1 !equalize_done [*2] |-> eq_req;
	endproperty
	a_eq_hold: assert property (p_eq_hold)
		else $error("equalize request lost");

	property p_clear;
		alert_write && !wr_data[AL_CV] && !alert_set[AL_CV] |=>
			!alert_flags[AL_CV];
	endproperty
	a_clear: assert property (p_clear)
		else $error("write zero did not clear alert");

	property p_alert_hold;
		!smbalert_drive_n && !ara_done |=> !smbalert_drive_n;
	endproperty
	a_alert_hold: assert property (p_alert_hold)
		else $error("alert pin released early");

	property p_alert_release;
		s_ara_finish |=> smbalert_drive_n;
	endproperty
	a_alert_release: assert property (p_alert_release)
		else $error("alert pin not released after response");

	property p_ro_hold;
		!meas_strobe |=> $stable(meas_reg);
	endproperty
	a_ro_hold: assert property (p_ro_hold)
		else $error("telemetry changed without strobe");

endmodule // charger_status_telemetry_regs

// ### verilog/charger_regs_pkg.sv
// Constants, field positions and carrier types for the charger status bank
// Functional notes
// - Undervoltage loop takeover sets alert bit 3
// - Input current loop takeover sets alert bit 2
// - Constant-current takeover sets alert bit 1
// - Constant-voltage takeover sets alert bit 0
// - Status word bits 13:0; bit 13 charging
// - Status bit 11 follows tracking pin high
// - Bit 10 set on equalize edge, held
// - Bit 9 shows gate-driver supply good
// - Bit 8 flags invalid cell-count pins
// - Bit 6 shows charging is permitted
// - Bit 5 shows frequency resistor missing
// - Bits 4 and 3 show protection shutdowns
// - Bit 2 shows input above battery
// - Bits 1 and 0 show supply lockouts
// - Battery voltage word at 0x3a
// - Input and system voltage words
// - Battery and input current words
// - Die temperature word at 0x3f
// - Thermistor ratio word at 0x40
// - Series resistance word plus retained current
// - Lithium temperature region from ratio thresholds
// - Chemistry pins encoded in bits 11:8
// - Writing zero clears; live condition re-raises
// - New alert holds alert pin low until ARA
package charger_regs_pkg;

	// Register sub-addresses
	localparam logic [7:0] ADDR_ALERTS = 8'h38;
	localparam logic [7:0] ADDR_STATUS = 8'h39;
	localparam logic [7:0] ADDR_VBAT = 8'h3a;
	localparam logic [7:0] ADDR_VIN = 8'h3b;
	localparam logic [7:0] ADDR_VSYS = 8'h3c;
	localparam logic [7:0] ADDR_IBAT = 8'h3d;
	localparam logic [7:0] ADDR_IIN = 8'h3e;
	localparam logic [7:0] ADDR_DIE_TEMP = 8'h3f;
	localparam logic [7:0] ADDR_NTC = 8'h40;
	localparam logic [7:0] ADDR_BSR = 8'h41;
	localparam logic [7:0] ADDR_REGION = 8'h42;
	localparam logic [7:0] ADDR_CHEM_CELLS = 8'h43;
	localparam logic [7:0] ADDR_BSR_CURRENT = 8'h48;

	// Alert bit positions
	localparam int AL_UVCL = 3;
	localparam int AL_IIN_LIMIT = 2;
	localparam int AL_CC = 1;
	localparam int AL_CV = 0;
	localparam int ALERT_W = 4;

	// Status word bit positions
	localparam int ST_CHARGER_ENABLED = 13;
	localparam int ST_MPPT = 11;
	localparam int ST_EQUALIZE = 10;
	localparam int ST_DRIVE_GOOD = 9;
	localparam int ST_CELL_ERROR = 8;
	localparam int ST_PERMITTED = 6;
	localparam int ST_NO_FREQ_RES = 5;
	localparam int ST_THERMAL = 4;
	localparam int ST_OVERVOLT = 3;
	localparam int ST_IN_ABOVE_BAT = 2;
	localparam int ST_SW_LOCKOUT = 1;
	localparam int ST_MEAS_LOCKOUT = 0;

	// Three-level pin codes from the pin detectors
	localparam logic [1:0] LVL_L = 2'h0;
	localparam logic [1:0] LVL_H = 2'h1;
	localparam logic [1:0] LVL_Z = 2'h2;

	// Chemistry codes; last lithium code bounds the region report
	localparam logic [3:0] CHEM_INVALID = 4'hf;
	localparam logic [3:0] CHEM_LAST_LITHIUM = 4'h6;
	localparam logic [3:0] CELLS_INVALID = 4'h0;
	localparam int REGION_THRESH_COUNT = 6;

	// Serial port constants
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Comparator and status inputs from the analog side
	typedef struct packed {
		logic charger_enabled;
		logic drive_supply_good;
		logic charge_permitted;
		logic missing_freq_resistor;
		logic thermal_shutdown;
		logic input_overvoltage;
		logic input_above_battery;
		logic int_supply_above_switch_lockout;
		logic int_supply_above_meas_lockout;
	} sys_in_type;

	// Regulation loop ownership flags from the charger core
	typedef struct packed {
		logic uvcl_active;
		logic iin_limit_active;
		logic constant_current;
		logic constant_voltage;
	} loop_type;

	// One set of measurement results
	typedef struct packed {
		logic [15:0] vbat;
		logic [15:0] vin;
		logic [15:0] vsys;
		logic [15:0] ibat;
		logic [15:0] iin;
		logic [15:0] die_temp;
		logic [15:0] ntc_ratio;
	} meas_type;

	// Serial port states
	typedef enum logic [10:0] {
		S_IDLE = 11'h001,
		S_ADDR = 11'h002,
		S_ADDR_ACK = 11'h004,
		S_SUB = 11'h008,
		S_SUB_ACK = 11'h010,
		S_WLO = 11'h020,
		S_WLO_ACK = 11'h040,
		S_WHI = 11'h080,
		S_WHI_ACK = 11'h100,
		S_RD = 11'h200,
		S_RD_ACK = 11'h400
	} port_state_type;

endpackage

// ### test/host_port_model.sv
// Two-wire bus master standing in for the host controller
`timescale 1ns/100ps
module host_port_model
	import charger_regs_pkg::*;
	#(
	parameter logic [6:0] DEV = 7'h2a // Arbitrary value
	)
	(
	// Clock and resolved data wire
	input wire logic clk,
	input wire logic sda_line,
	// Bus pins, data low while driven
	output logic scl,
	output logic sda_drive_n
	);

	int missed;

	// Idle bus: both wires released to the pull-ups
	initial begin
		scl = 1'b1;
		sda_drive_n = 1'b1;
		missed = 0;
	end

	// Nine clocks per phase, above the three the port needs
	task automatic tick();
		repeat (9) @(negedge clk);
	endtask

	// Data only moves a phase after SCL falls, never beside an edge
	task automatic clk_bit(input logic b, output logic seen);
		sda_drive_n = b;
		tick();
		scl = 1'b1;
		tick();
		seen = sda_line;
		scl = 1'b0;
		tick();
	endtask

	// Also serves as repeated start from a low clock
	task automatic start();
		sda_drive_n = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_drive_n = 1'b0;
		tick();
		scl = 1'b0;
		tick();
	endtask

	task automatic stop();
		sda_drive_n = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_drive_n = 1'b1;
		tick();
	endtask

	// Byte out MSB first; a missing acknowledge is counted
	task automatic wbyte(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		if (s !== 1'b0)
			missed++;
	endtask

	// Byte in; the last byte of a read is refused with a NACK
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(last, s);
	endtask

	// Word write, low byte first; zero bits clear alert flags
	task automatic write_word(input logic [7:0] sub, input logic [15:0] v);
		start();
		wbyte({DEV, 1'b0});
		wbyte(sub);
		wbyte(v[7:0]);
		wbyte(v[15:8]);
		stop();
	endtask

	task automatic read_word(input logic [7:0] sub, output logic [15:0] v);
		start();
		wbyte({DEV, 1'b0});
		wbyte(sub);
		start();
		wbyte({DEV, 1'b1});
		rbyte(1'b0, v[7:0]);
		rbyte(1'b1, v[15:8]);
		stop();
	endtask

	// Alert response read, one byte
	task automatic ara(output logic [7:0] d);
		start();
		wbyte({ALERT_RESPONSE_ADDR, 1'b1});
		rbyte(1'b1, d);
		stop();
	endtask

endmodule // host_port_model

// ### test/tb_top.sv
// Register-level testbench for the charger status bank
`timescale 1ns/100ps
module tb_top;
	import charger_regs_pkg::*;

	localparam logic [6:0] DEV = 7'h2a; // Arbitrary value

	logic clk, reset, scl, sda_host_n, sda_out, sda_drive_n;
	logic smb_out, smb_drive_n, mppt, eq, eq_done;
	logic meas_strobe, bsr_strobe;
	logic [3:0] chem, alert_en;
	logic [5:0] cells;
	logic [15:0] bsr, bsr_cur, e;
	logic [5:0][15:0] thresh;
	logic [8:0] st;
	logic [7:0] b;
	sys_in_type sys_pins;
	loop_type loop;
	meas_type meas;
	int err_total, n_compared;
	logic [3:0] chem_pins [9] = '{4'h0, 4'h5, 4'h2, 4'h8, 4'h1, 4'h6, 4'h9,
		4'ha, 4'h4};

	// Open-drain wires with pull-ups
	wire logic sda_line = sda_host_n & (sda_drive_n | sda_out);
	wire logic smb_line = smb_drive_n | smb_out;

	charger_status_telemetry_regs #(.DEVICE_ADDR(DEV)) i_charger_status_telemetry_regs (
		.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_drive_n(sda_drive_n),
		.smbalert_in(smb_line), .smbalert_out(smb_out),
		.smbalert_drive_n(smb_drive_n), .sys_pins(sys_pins),
		.mppt_pin(mppt), .equalize_pin(eq), .chemistry_select_pins(chem),
		.cell_select_pins(cells), .loop_active(loop),
		.alert_enable(alert_en), .equalize_done(eq_done),
		.region_thresh(thresh), .meas(meas), .meas_strobe(meas_strobe),
		.bsr_value(bsr), .resistance_calc_current(bsr_cur),
		.bsr_strobe(bsr_strobe));

	host_port_model #(.DEV(DEV)) i_host_port_model (
		.clk(clk), .sda_line(sda_line), .scl(scl),
		.sda_drive_n(sda_host_n));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] sub, input logic [15:0] exp);
		logic [15:0] v;
		i_host_port_model.read_word(sub, v);
		check(v, exp);
	endtask

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		$display("ERROR at %0t: run too long", $time);
		end_sim();
	end

	initial begin
		err_total = 0;
		n_compared = 0;
		reset = 1'b1;
		sys_pins = '0;
		mppt = 1'b0;
		eq = 1'b0;
		eq_done = 1'b0;
		chem = 4'h0;
		cells = 6'h01;
		loop = '0;
		alert_en = 4'h0;
		thresh = {16'h0800, 16'h1000, 16'h1800, 16'h2000, 16'h2800, 16'h3000};
		meas = '0;
		meas_strobe = 1'b0;
		bsr = 16'h0000;
		bsr_cur = 16'h0000;
		bsr_strobe = 1'b0;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		rd(ADDR_ALERTS, 16'h0000);
		check(16'(smb_drive_n), 16'h0001);

		// Three pin patterns; equalize edge on the second, done on the third
		for (int p = 0; p < 3; p++) begin
			@(negedge clk);
			st = (p == 0) ? 9'h0aa : 9'h155;
			sys_pins = st;
			mppt = p[0];
			cells = (p == 0) ? 6'h01 : 6'h00;
			eq = (p == 1);
			eq_done = (p == 2);
			e = {2'h0, st[8], 1'b0, p[0], p == 1, st[7], p != 0, 1'b0, st[6:0]};
			rd(ADDR_STATUS, e);
		end
		$display("status test done");

		// Results held from one strobe; later inputs and writes ignored
		@(negedge clk);
		eq_done = 1'b0;
		meas = {16'h8001, 16'h1234, 16'h2345, 16'hfedc, 16'h3456, 16'h2eea,
			16'h2400};
		bsr = 16'h0777;
		bsr_cur = 16'hc001;
		meas_strobe = 1'b1;
		bsr_strobe = 1'b1;
		@(negedge clk);
		meas_strobe = 1'b0;
		bsr_strobe = 1'b0;
		meas = '0;
		bsr = 16'h0000;
		i_host_port_model.write_word(ADDR_VBAT, 16'h5a5a);
		rd(ADDR_VBAT, 16'h8001);
		rd(ADDR_VIN, 16'h1234);
		rd(ADDR_VSYS, 16'h2345);
		rd(ADDR_IBAT, 16'hfedc);
		rd(ADDR_IIN, 16'h3456);
		rd(ADDR_DIE_TEMP, 16'h2eea);
		rd(ADDR_NTC, 16'h2400);
		rd(ADDR_BSR, 16'h0777);
		rd(ADDR_BSR_CURRENT, 16'hc001);
		rd(8'h50, 16'h0000);
		$display("telemetry test done");

		// Every valid chemistry code; region only reported for lithium
		cells = 6'h01;
		for (int c = 0; c < 9; c++) begin
			@(negedge clk);
			chem = chem_pins[c];
			rd(ADDR_CHEM_CELLS, {4'h0, 4'(c), 8'h01});
			if (c == 0 || c == 8)
				rd(ADDR_REGION, (c == 0) ? 16'h0003 : 16'h0000);
		end
		$display("chemistry test done");

		// Each loop in turn: raise, answer, clear while live, then drop
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			alert_en = 4'(1 << i);
			loop = loop_type'(4'(1 << i));
			repeat (3) @(negedge clk);
			check(16'(smb_drive_n), 16'h0000);
			rd(ADDR_ALERTS, 16'(1 << i));
			i_host_port_model.ara(b);
			check(16'(b), {8'h0, DEV, 1'b0});
			check(16'(smb_drive_n), 16'h0001);
			i_host_port_model.write_word(ADDR_ALERTS, 16'h0000);
			check(16'(smb_drive_n), 16'h0000);
			rd(ADDR_ALERTS, 16'(1 << i));
			@(negedge clk);
			loop = '0;
			i_host_port_model.write_word(ADDR_ALERTS, 16'h0000);
			rd(ADDR_ALERTS, 16'h0000);
			i_host_port_model.ara(b);
			check(16'(smb_drive_n), 16'h0001);
		end
		$display("alert test done");
		check(16'(i_host_port_model.missed), 16'h0000);
		end_sim();
	end

endmodule // tb_top
